// file: logic/sais_pkg.sv
`default_nettype none
package sais_pkg;

   // clock and sync timing
   localparam int unsigned CLK_FREQ_HZ        = 200_000_000;
   localparam int unsigned LINE_MIN_FREQ_HZ   = 1000;    // line sync must run above this
   localparam int unsigned FRAME_MIN_FREQ_HZ  = 20;      // frame sync must run above this
   // longest period in cycles, rounded down
   localparam int unsigned LINE_LIMIT_CYCLES  = CLK_FREQ_HZ / LINE_MIN_FREQ_HZ;
   localparam int unsigned FRAME_LIMIT_CYCLES = CLK_FREQ_HZ / FRAME_MIN_FREQ_HZ;
   localparam int unsigned JITTER_CYCLES      = 4;       // allowed spread of high/low times
   localparam int unsigned TIME_W             = 24;

   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_INPUT_CHARACTERISTICS = 8'h01;
   localparam logic [7:0] IDX_CHANNEL_SYNC_ACTIVITY = 8'h02;
   localparam logic [7:0] IDX_UNUSED_STATUS         = 8'h03;
   localparam logic [7:0] IDX_EVENT_FLAGS           = 8'h04;
   localparam logic [7:0] IDX_EVENT_MASK            = 8'h05;
   localparam logic [7:0] IDX_CHANNEL_SELECT        = 8'h06;

   // field positions
   localparam int unsigned PLL_LOCKED_BIT       = 7;
   localparam int unsigned CH1_FIELD_LSB        = 4;
   localparam int unsigned FLAG_CH0_CHANGED     = 0;
   localparam int unsigned FLAG_CH1_CHANGED     = 1;
   localparam int unsigned FLAG_INPUT_DISRUPTED = 4;
   localparam int unsigned FLAG_INPUT_SETTLED   = 5;
   localparam int unsigned FLAG_FRAME_SYNC      = 6;
   localparam int unsigned FLAG_PHASE_ADJUST    = 7;

   // reset values
   localparam logic [7:0] EVENT_MASK_RESET     = 8'hff;
   localparam logic [7:0] EVENT_FLAGS_RESET    = 8'h00;
   localparam logic [7:0] FLAG_IMPLEMENTED     = 8'hf3;  // bits 2 and 3 never set
   localparam logic       CHANNEL_SEL_RESET    = 1'b0;

   // green-embedded sync activity codes
   localparam logic [1:0] GREEN_INACTIVE       = 2'h0;
   localparam logic [1:0] GREEN_NON_PERIODIC   = 2'h1;
   localparam logic [1:0] GREEN_PERIODIC       = 2'h2;

   localparam logic [1:0] HTRANS_NONSEQ        = 2'h2;
   localparam logic       HRESP_OKAY           = 1'b0;

   // activity of one channel, laid out as in the activity register
   typedef struct packed {
      logic [1:0] green;
      logic       frame;
      logic       line;
   } sais_chan_act_type;

   // what a channel reports for change detection
   typedef struct packed {
      sais_chan_act_type act;
      logic              line_pol;
      logic              frame_pol;
   } sais_chan_state_type;

   // latched address phase
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] index;
   } sais_addr_phase_type;

endpackage
`default_nettype wire

// file: logic/sais_sync_status.sv
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module sais_sync_status
   import sais_pkg::*;
#(
   parameter int unsigned LINE_LIMIT  = LINE_LIMIT_CYCLES,
   parameter int unsigned FRAME_LIMIT = FRAME_LIMIT_CYCLES,
   parameter int unsigned JITTER      = JITTER_CYCLES
) (
   // core clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,

   // register port, single slave on the bus
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,

   // sync pins, asynchronous to hclk
   input  wire logic        ch0_line_sync_input,
   input  wire logic        ch0_frame_sync_input,
   input  wire logic        ch0_green_embedded_sync,
   input  wire logic        ch1_line_sync_input,
   input  wire logic        ch1_frame_sync_input,
   input  wire logic        ch1_green_embedded_sync,
   input  wire logic        pll_locked_pin,

   // core-side event and interrupt request
   input  wire logic        phase_adjust_done_event,
   output logic             irq
);

   // three monitored inputs per channel, two channels

   localparam int unsigned NUM_SIG = 6;

   // true when two measured times agree within the allowed jitter
   function automatic logic times_match(input logic [TIME_W-1:0] a,
                                        input logic [TIME_W-1:0] b);
      logic [TIME_W-1:0] diff;
      // unsigned difference, so order of the two times does not matter
      if (a > b) begin
         diff = a - b;
      end else begin
         diff = b - a;
      end
      // a spread of up to the window still counts as consistent
      return diff <= TIME_W'(JITTER);
   endfunction

   // per-input results of the monitors, indexed in pin order

   // pins in channel order: line, frame, green for ch0 then ch1
   logic [NUM_SIG-1:0] sync_pins;
   logic [NUM_SIG-1:0] sig_seen;     // transitions seen within the limit
   logic [NUM_SIG-1:0] sig_stable;   // periodic with consistent high/low times
   logic [NUM_SIG-1:0] sig_pol;      // one when the signal is active low
   logic [NUM_SIG-1:0] sig_active_edge;

   // index 3*channel + 0 line, + 1 frame, + 2 green
   assign sync_pins = {
      ch1_green_embedded_sync,
      ch1_frame_sync_input,
      ch1_line_sync_input,
      ch0_green_embedded_sync,
      ch0_frame_sync_input,
      ch0_line_sync_input
   };

   // one period/width monitor per sync input
   // frame inputs get the long limit, line and green inputs the short one
   // counters are TIME_W bits, so the frame limit must fit in that width
   for (genvar i = 0; i < NUM_SIG; i++) begin : g_mon
      localparam int unsigned LIMIT = ((i % 3) == 1) ? FRAME_LIMIT : LINE_LIMIT;
      logic [2:0]        pipe;       // [0],[1] synchroniser, [2] history
      logic [TIME_W-1:0] cnt;
      logic [TIME_W-1:0] hi_time;
      logic [TIME_W-1:0] lo_time;
      logic              hi_ok;
      logic              lo_ok;
      logic              seen;
      logic              edge_seen;
      logic              timeout;
      logic [TIME_W:0]   period;

      // an edge is a difference between the settled bit and its history
      // only the second synchroniser flop and the history are read here
      assign edge_seen = pipe[2] ^ pipe[1];
      // saturation point doubles as the no-activity timeout
      assign timeout   = (cnt == TIME_W'(LIMIT));
      // one extra bit so the sum of two saturated times cannot wrap
      assign period    = {1'b0, hi_time} + {1'b0, lo_time};

      // pins are asynchronous to hclk, so two flops before any use
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            pipe <= 3'h0;
         end else begin
            pipe <= {pipe[1:0], sync_pins[i]};
         end
      end

      // cycles since the last edge, saturating at the limit
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cnt <= '0;
         end else if (edge_seen) begin
            cnt <= TIME_W'(1);
         end else if (!timeout) begin
            cnt <= cnt + TIME_W'(1);
         end
      end

      // a rising edge ends a low time, a falling edge ends a high time
      // each time is compared with the previous one of the same phase,
      // so two whole periods pass before a signal can count as stable
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            hi_time <= '0;
            lo_time <= '0;
            hi_ok   <= 1'b0;
            lo_ok   <= 1'b0;
            seen    <= 1'b0;
         end else if (timeout) begin
            // an edge too late means no periodic signal above the minimum rate
            hi_ok <= 1'b0;
            lo_ok <= 1'b0;
            seen  <= 1'b0;
         end else if (edge_seen) begin
            seen <= 1'b1;
            if (pipe[1]) begin
               lo_time <= cnt;
               lo_ok   <= times_match(cnt, lo_time);
            end else begin
               hi_time <= cnt;
               hi_ok   <= times_match(cnt, hi_time);
            end
         end
      end

      // results handed out of the monitor
      // stable needs both phases consistent and a period under the limit
      // polarity is only meaningful while the signal is active
      assign sig_seen[i]        = seen;
      assign sig_stable[i]      = hi_ok & lo_ok & (period < (TIME_W + 1)'(LIMIT));
      assign sig_pol[i]         = hi_time > lo_time;   // longer high phase means active low
      assign sig_active_edge[i] = edge_seen & (pipe[1] ^ sig_pol[i]);
   end

   // activity fields of both channels
   // chan_act is what software reads, chan_now adds the polarities,
   // chan_prev is last cycle's view for change detection
   sais_chan_act_type   chan_act [2];
   sais_chan_state_type chan_now [2];
   sais_chan_state_type chan_prev [2];

   for (genvar c = 0; c < 2; c++) begin : g_chan
      // green code: periodic beats merely seen, seen beats nothing
      always_comb begin
         chan_act[c].line  = sig_stable[3*c];
         chan_act[c].frame = sig_stable[3*c+1];
         if (sig_stable[3*c+2]) begin
            chan_act[c].green = GREEN_PERIODIC;
         end else if (sig_seen[3*c+2]) begin
            chan_act[c].green = GREEN_NON_PERIODIC;
         end else begin
            chan_act[c].green = GREEN_INACTIVE;
         end
      end

      // state that a change flag watches: activity plus polarities
      assign chan_now[c] = '{
         act:       chan_act[c],
         line_pol:  sig_pol[3*c],
         frame_pol: sig_pol[3*c+1]
      };

      // previous view, compared each cycle to spot changes
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            chan_prev[c] <= '0;
         end else begin
            chan_prev[c] <= chan_now[c];
         end
      end
   end

   // pll lock indication crosses in from the analog side
   // a level, so two flops suffice; a short lock glitch may be missed
   logic [1:0] pll_sync;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pll_sync <= 2'h0;
      end else begin
         pll_sync <= {pll_sync[0], pll_locked_pin};
      end
   end

   // software registers
   // flags are sticky, mask is read/write, select steers flags 4 to 6
   logic [7:0] event_flags;
   logic [7:0] event_mask;
   logic       channel_select;

   // selected channel's line and frame monitors
   logic [1:0] sel_stable;
   logic [1:0] sel_stable_q;
   logic       sel_edge;
   logic       sel_frame_edge;

   // frame and line stable bits of the chosen channel, frame in bit 1
   // a change of selection can itself look like a disruption or settling
   assign sel_stable     = channel_select ? sig_stable[4:3] : sig_stable[1:0];
   assign sel_frame_edge = channel_select ? sig_active_edge[4] : sig_active_edge[1];

   // remembers the selected channel's state one cycle back; not cleared on a reselect
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_stable_q <= 2'h0;
      end else begin
         sel_stable_q <= sel_stable;
      end
   end

   // events raised this cycle
   // each is a one-cycle strobe; the sticky register holds it for software
   // disrupted means a selected monitor fell from stable, settled the reverse
   // flags 0 and 1 ignore period changes, only activity and polarity count
   logic [7:0] events;
   always_comb begin
      events = 8'h00;
      events[FLAG_CH0_CHANGED]     = chan_now[0] != chan_prev[0];
      events[FLAG_CH1_CHANGED]     = chan_now[1] != chan_prev[1];
      events[FLAG_INPUT_DISRUPTED] = |(sel_stable_q & ~sel_stable);
      events[FLAG_INPUT_SETTLED]   = |(sel_stable & ~sel_stable_q);
      events[FLAG_FRAME_SYNC]      = sel_frame_edge;
      events[FLAG_PHASE_ADJUST]    = phase_adjust_done_event;
   end

   // ahb-lite address phase, always zero wait states
   // nothing here ever stalls, so hreadyout and hresp are constants
   // hsize is ignored: every register is one aligned word
   sais_addr_phase_type aph;
   logic                take;
   logic                wr_now;

   assign take      = hsel & hready & htrans[1];
   assign wr_now    = aph.valid & aph.write;
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;


   // address phase kept for the write data that follows one cycle later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph <= '0;
      end else if (hready) begin
         aph <= '{valid: take, write: hwrite, index: haddr[9:2]};
      end
   end

   // register value seen by a read of the given index
   // reads have no side effects, flags clear only on a write of ones
   function automatic logic [7:0] read_value(input logic [7:0] idx);
      unique case (idx)
         IDX_INPUT_CHARACTERISTICS: read_value = {pll_sync[1], 7'h00};
         IDX_CHANNEL_SYNC_ACTIVITY: read_value = {chan_act[1], chan_act[0]};
         IDX_EVENT_FLAGS:           read_value = event_flags;
         IDX_EVENT_MASK:            read_value = event_mask;
         IDX_CHANNEL_SELECT:        read_value = {7'h00, channel_select};
         default:                   read_value = 8'h00;   // unused and unmapped read zero
      endcase
   endfunction

   // read data sampled at the address edge, stands through the data phase
   // a write ending at that same edge is not yet visible to this read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         hrdata <= {24'h00_0000, read_value(haddr[9:2])};
      end
   end

   // sticky flags; a new event wins over a clear in the same cycle
   // so an event is never lost to an acknowledge racing with it
   // bits 2 and 3 are forced to zero whatever is written
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         event_flags <= EVENT_FLAGS_RESET;
      end else if (wr_now && aph.index == IDX_EVENT_FLAGS) begin
         event_flags <= ((event_flags & ~hwdata[7:0]) | events) & FLAG_IMPLEMENTED;
      end else begin
         event_flags <= (event_flags | events) & FLAG_IMPLEMENTED;
      end
   end

   // mask, all ones at reset so nothing interrupts until software opens it
   // reserved bits are stored as written; software keeps them at one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         event_mask <= EVENT_MASK_RESET;
      end else if (wr_now && aph.index == IDX_EVENT_MASK) begin
         event_mask <= hwdata[7:0];
      end
   end

   // input channel selection for the disruption, settling and frame flags
   // only bit 0 is kept; other written bits are dropped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         channel_select <= CHANNEL_SEL_RESET;
      end else if (wr_now && aph.index == IDX_CHANNEL_SELECT) begin
         channel_select <= hwdata[0];
      end
   end

   // level interrupt, registered so it is glitch free
   // costs one cycle of latency after a flag sets or clears
   // stays high until every unmasked flag has been cleared
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(event_flags & ~event_mask);
      end
   end

endmodule
`default_nettype wire

// file: tb/sais_sync_source.sv
`timescale 1ns/10ps
`default_nettype none
module sais_sync_source (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [5:0] run,    // ch1 green, frame, line, ch0 green, frame, line
   input  wire logic       noisy,  // ch1 green shows aperiodic edges
   output logic [5:0]      pins
);
   logic [3:0] cnt_l;
   logic [6:0] cnt_f;
   logic [4:0] nz_cnt;
   logic [4:0] nz_len;
   logic       nz;
   // line period 16 (4 high), frame period 100 (10 high), both well inside the limits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_l  <= 4'h0;
         cnt_f  <= 7'h00;
         nz_cnt <= 5'h00;
         nz_len <= 5'h05;
         nz     <= 1'b0;
      end else begin
         cnt_l  <= cnt_l + 4'h1;
         cnt_f  <= (cnt_f == 7'd99) ? 7'h00 : cnt_f + 7'h01;
         nz_cnt <= nz_cnt + 5'h01;
         // run lengths step by 6, beyond the jitter window, so never settle
         if (nz_cnt >= nz_len) begin
            nz     <= ~nz;
            nz_cnt <= 5'h00;
            nz_len <= (nz_len >= 5'd23) ? 5'd5 : nz_len + 5'd6;
         end
      end
   end
   // idle pins stand still at low outside activity, except ch1 green, which toggles whenever noisy is set
   always_comb begin
      pins    = run & {cnt_l < 4'd4, cnt_f < 7'd10, cnt_l < 4'd4, cnt_l < 4'd4, cnt_f < 7'd10,
                       cnt_l < 4'd4};
      pins[5] = noisy ? nz : pins[5];
   end
endmodule
`default_nettype wire

// file: tb/sais_sync_status_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sais_sync_status_bench
   import sais_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, noisy, mon_rd;
   logic        pll_locked_pin, phase_adjust_done_event;
   logic [5:0]  run, pins;
   logic [31:0] haddr, hwdata, hrdata, lfsr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  m;
   logic [15:0] n;
   logic [15:0] note_q[$];
   int          bad_count, tests_run, i;

   sais_sync_status #(.LINE_LIMIT(64), .FRAME_LIMIT(512)) sais_sync_status_inst (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .ch0_line_sync_input(pins[0]),
      .ch0_frame_sync_input(pins[1]), .ch0_green_embedded_sync(pins[2]),
      .ch1_line_sync_input(pins[3]), .ch1_frame_sync_input(pins[4]),
      .ch1_green_embedded_sync(pins[5]), .pll_locked_pin(pll_locked_pin),
      .phase_adjust_done_event(phase_adjust_done_event), .irq(irq));
   sais_sync_source sais_sync_source_inst (.hclk(hclk), .hresetn(hresetn), .run(run),
      .noisy(noisy), .pins(pins));

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task summarize();
      if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one single transfer; holds each phase until hready is sampled high
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {22'h00_0000, idx, 2'b00};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      hsize  <= 3'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask

   task wr(input logic [7:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d);
   endtask

   task rd(input logic [7:0] idx, input logic [7:0] care, input logic [7:0] exp);
      note_q.push_back({care, exp});
      bus(1'b0, idx, lfsr);
   endtask

   task idle(input int cycles);
      repeat (cycles) @(posedge hclk);
   endtask

   // irq looked at once the edge has settled, then back onto the edge
   task chk_irq(input logic exp);
      #1 chk({7'h00, irq}, {7'h00, exp});
      @(posedge hclk);
   endtask

   // read data is settled by the falling edge of its data phase
   always @(posedge hclk) mon_rd <= hsel && hreadyout && htrans[1] && !hwrite;
   always @(negedge hclk) begin
      if (mon_rd === 1'b1) begin
         n = note_q.pop_front();
         chk(hrdata[7:0] & n[15:8], n[7:0]);
      end
   end

   initial begin
      repeat (20000) @(posedge hclk);
      bad_count++;
      summarize();
   end

   initial begin
      {hsel, hwrite, noisy, mon_rd, pll_locked_pin, phase_adjust_done_event} = 6'h00;
      {haddr, hwdata, htrans, hsize, run} = 0;
      hresetn = 1'b0;
      lfsr    = 32'h0000_43c7;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(IDX_EVENT_MASK, 8'hff, EVENT_MASK_RESET);
      rd(IDX_EVENT_FLAGS, 8'hff, EVENT_FLAGS_RESET);
      rd(IDX_CHANNEL_SYNC_ACTIVITY, 8'hff, 8'h00);
      rd(IDX_UNUSED_STATUS, 8'hff, 8'h00);
      rd(8'h3f, 8'hff, 8'h00);
      chk_irq(1'b0);
      pll_locked_pin <= 1'b1;
      idle(4);
      rd(IDX_INPUT_CHARACTERISTICS, 8'hff, 8'h80);
      pll_locked_pin <= 1'b0;
      idle(4);
      rd(IDX_INPUT_CHARACTERISTICS, 8'hff, 8'h00);
      // random masks, reserved bits kept at one
      for (i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         m    = lfsr[7:0] | 8'h0c;
         wr(IDX_EVENT_MASK, {lfsr[31:8], m});
         rd(IDX_EVENT_MASK, 8'hff, m);
      end
      wr(IDX_EVENT_MASK, 32'h0000_007f);
      phase_adjust_done_event <= 1'b1;
      @(posedge hclk);
      phase_adjust_done_event <= 1'b0;
      idle(3);
      chk_irq(1'b1);
      rd(IDX_EVENT_FLAGS, 8'h80, 8'h80);
      wr(IDX_EVENT_FLAGS, 32'h0000_0080);
      idle(2);
      chk_irq(1'b0);
      rd(IDX_EVENT_FLAGS, 8'h80, 8'h00);
      // channel 0 acquires all three syncs
      wr(IDX_EVENT_MASK, 32'h0000_00df);
      run <= 6'h07;
      idle(600);
      rd(IDX_CHANNEL_SYNC_ACTIVITY, 8'hff, 8'h0b);
      rd(IDX_EVENT_FLAGS, 8'h73, 8'h61);
      chk_irq(1'b1);
      wr(IDX_EVENT_FLAGS, 32'h0000_00ff);
      wr(IDX_EVENT_MASK, 32'h0000_00bf);
      idle(120);
      chk_irq(1'b1);
      // channel 1 with aperiodic green edges
      wr(IDX_EVENT_MASK, 32'h0000_00ff);
      wr(IDX_EVENT_FLAGS, 32'h0000_00ff);
      run   <= 6'h1f;
      noisy <= 1'b1;
      idle(600);
      rd(IDX_CHANNEL_SYNC_ACTIVITY, 8'hff, 8'h7b);
      rd(IDX_EVENT_FLAGS, 8'h02, 8'h02);
      // selected line sync lost
      wr(IDX_EVENT_MASK, 32'h0000_00ef);
      wr(IDX_EVENT_FLAGS, 32'h0000_00ff);
      run <= 6'h1e;
      idle(200);
      rd(IDX_CHANNEL_SYNC_ACTIVITY, 8'h0f, 8'h0a);
      rd(IDX_EVENT_FLAGS, 8'h11, 8'h11);
      chk_irq(1'b1);
      summarize();
   end
endmodule
`default_nettype wire

// file: tb/sais_sync_status_sva.sv
`timescale 1ns/10ps
`default_nettype none
module sais_sync_status_sva
   import sais_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        phase_adjust_done_event,
   input wire logic        irq
);
   logic       take;
   logic       dp_wr;
   logic [7:0] dp_idx;
   logic [7:0] mask_seen;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   assign take = hsel && hready && htrans[1];
   // shadow of the mask, so irq gating can be judged from the bus alone
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr     <= 1'b0;
         dp_idx    <= 8'h00;
         mask_seen <= EVENT_MASK_RESET;
      end else begin
         dp_wr  <= take && hwrite;
         dp_idx <= haddr[9:2];
         if (dp_wr && dp_idx == IDX_EVENT_MASK) mask_seen <= hwdata[7:0];
      end
   end
   sequence s_read(logic [7:0] idx);
      take && !hwrite && haddr[9:2] == idx;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready and okay");
   a_upper_zero: assert property (hrdata[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
   a_pll_field: assert property (s_read(IDX_INPUT_CHARACTERISTICS) |=> hrdata[6:0] == 7'h00)
      else $error("lock register low bits not zero");
   a_flag_reserved: assert property (s_read(IDX_EVENT_FLAGS) |=> (hrdata[7:0] & ~FLAG_IMPLEMENTED) == 8'h00)
      else $error("reserved flag bits set");
   a_unused_zero: assert property (s_read(IDX_UNUSED_STATUS) |=> hrdata == 32'h0000_0000)
      else $error("unused register not zero");
   a_mask_readback: assert property (s_read(IDX_EVENT_MASK) |=> hrdata[7:0] == mask_seen)
      else $error("mask read differs from written value");
   a_irq_masked: assert property (mask_seen == 8'hff && $past(mask_seen) == 8'hff |-> !irq)
      else $error("irq high with all events masked");
   a_phase_irq: assert property (phase_adjust_done_event && !mask_seen[7] |-> ##[1:2] irq)
      else $error("phase adjust done gave no irq");
endmodule
bind sais_sync_status sais_sync_status_sva sais_sync_status_sva_inst (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .phase_adjust_done_event(phase_adjust_done_event), .irq(irq));
`default_nettype wire
